// ---- tlseq_top.sv ----
/*
  Tension loop sequencer: enable handling, creep and ramp phases, loop-good,
  gain set selection and shadowing, setpoint source and storage, diameter and
  feedforward calibration, and feedforward output with diameter-adapted proportional gain.
  Assumes the PID arithmetic sits outside and reads the active gains, the
  target and the creep command; nonvolatile storage takes a write pulse.
*/
`timescale 1ns/100ps
module tlseq_top
  import tlseq_pkg::*;
#(
  parameter int HOLD_CYCLES = HOLD_CYC
) (
  // Clock and reset.
  input  wire logic            clock,
  input  wire logic            nrst,
  // Machine controller digital lines.
  input  wire logic            runIn,
  input  wire logic [SELW-1:0] setSelect,
  output logic                 loopGood,
  // Serial command strobes.
  input  wire logic            serEnable,
  input  wire logic            serDisable,
  input  wire logic            serSetpointWr,
  input  wire logic            serSetpointNv,
  input  wire logic [DW-1:0]   serSetpoint,
  // Configuration.
  input  wire logic [1:0]      outputType,
  input  wire logic [DW-1:0]   creepRate,
  input  wire logic [DW-1:0]   creepThreshold,
  input  wire logic            setpointExternal,
  input  wire logic [DW-1:0]   refScale,
  input  wire logic [1:0]      ffMode,
  // Parameter editing.
  input  wire logic            editMode,
  input  wire logic [1:0]      editSet,
  input  wire logic            editGainWr,
  input  wire logic [GW-1:0]   editProp,
  input  wire logic [GW-1:0]   editInteg,
  input  wire logic [GW-1:0]   editDeriv,
  input  wire logic [DW-1:0]   editShare,
  input  wire logic            paramChange,
  // Keys and entry.
  input  wire logic            keySetpoint,
  input  wire logic            keyConfirm,
  input  wire logic            keyExit,
  input  wire logic [DW-1:0]   keyValue,
  input  wire logic            calDiamSmall,
  input  wire logic            calDiamLarge,
  input  wire logic            calFf,
  input  wire logic [DW-1:0]   calTorque,
  // Measured and analogue values.
  input  wire logic [DW-1:0]   tension,
  input  wire logic [DW-1:0]   analogRef,
  input  wire logic [DW-1:0]   diamVolt,
  input  wire logic [DW-1:0]   lineSpeed,
  input  wire logic [DW-1:0]   pidOut,
  // Outputs to loop arithmetic and drive.
  output logic [DW-1:0]        driveOut,
  output logic                 creepActive,
  output logic [DW-1:0]        target,
  output logic [GW-1:0]        activeProp,
  output logic [GW-1:0]        activeInteg,
  output logic [GW-1:0]        activeDeriv,
  output logic [DW-1:0]        activeShare,
  output logic [1:0]           activeSet,
  output logic                 setpointEdit,
  output logic                 nvWrite,
  output logic [DW-1:0]        nvSetpoint,
  output logic                 ffValid,
  output logic [DW-1:0]        diameter
);
  tlseq_state_t state;
  tlseq_state_t next_state;
  logic [2:0]      syncIn;
  logic            runSync;
  logic [1:0]      selSync;
  logic            bySerial;
  logic            held;
  logic [GW-1:0]   propSet  [NSETS];
  logic [GW-1:0]   integSet [NSETS];
  logic [GW-1:0]   derivSet [NSETS];
  logic [GW-1:0]   propAct  [NSETS];
  logic [GW-1:0]   integAct [NSETS];
  logic [GW-1:0]   derivAct [NSETS];
  logic [DW-1:0]   shareEdit;
  logic            editPrev;
  logic [DW-1:0]   setpoint;
  logic [1:0]      typePrev;
  logic [DW-1:0]   ffValue;
  logic [DW-1:0]   ffDiam;
  logic [DW-1:0]   diamS;
  logic [DW-1:0]   voltS;
  logic [DW-1:0]   diamL;
  logic [DW-1:0]   voltL;

  tlseq_sync #(.W(3)) uSync (
    .clock(clock),
    .nrst (nrst),
    .din  ({runIn, setSelect}),
    .dout (syncIn)
  );
  assign runSync = syncIn[2];
  assign selSync = syncIn[1:0];

  tlseq_hold #(.HOLD(HOLD_CYCLES)) uHold (
    .clock(clock),
    .nrst (nrst),
    .key  (keySetpoint && !setpointEdit),
    .held (held)
  );

  // Enable and disable requests.
  wire enableReq  = runSync || serEnable;
  wire disableReq = bySerial ? serDisable : (!runSync || serDisable);
  wire isOff      = (state == ST_OFF);
  wire autoStart  = (creepRate != 16'h0000) && (creepThreshold != 16'h0000);
  wire creepDone  = !autoStart || (tension >= creepThreshold);

  // Zero level of the chosen output type.
  wire [DW-1:0] zeroLevel = (outputType == OUT_MA4) ? ZERO_MA4 :
                            (outputType == OUT_MA0) ? ZERO_MA0 : ZERO_VOLT;

  // Setpoint source: external analogue input scaled, else the stored value.
  wire [2*DW-1:0] refProduct = analogRef * refScale;
  wire [DW-1:0]   effSetpoint = setpointExternal ? refProduct[2*DW-1:DW] : setpoint;

  // Diameter from sensor calibration or from line speed over output.
  wire [DW-1:0] voltSpan = voltL - voltS;
  wire [DW-1:0] diamSpan = diamL - diamS;
  wire [DW-1:0] voltOff  = (diamVolt > voltS) ? (diamVolt - voltS) : 16'h0000;
  wire [2*DW-1:0] extProd = voltOff * diamSpan;
  wire [DW-1:0] extDiam  = (voltSpan == 16'h0000) ? diamS :
                           16'(diamS + 16'(extProd / {16'h0000, voltSpan}));
  wire [DW-1:0] intDiam  = (pidOut == 16'h0000) ? DIAM_RESET :
                           16'(({lineSpeed, 8'h00}) / {8'h00, pidOut});
  wire ffOn = (ffMode != 2'h0) && ffValid;
  wire [DW-1:0] diamNow  = (ffMode == 2'h2) ? intDiam : extDiam;

  // Feedforward output scales with diameter against the calibration diameter.
  wire [2*DW-1:0] ffProd = ffValue * diamNow;
  wire [DW-1:0]   ffOut  = (ffDiam == 16'h0000) ? ffValue :
                           16'(ffProd / {16'h0000, ffDiam});
  wire [2*DW-1:0] ffCal  = calTorque * effSetpoint;
  wire [DW-1:0]   ffNew  = 16'(ffCal / {16'h0000, PERCENT_FULL});

  // Active proportional gain adapted to diameter while feedforward runs.
  wire [2*GW-1:0] propScaled = propAct[activeSet] * diamNow;
  wire [GW-1:0]   propAdapt  = (ffOn && ffDiam != 16'h0000) ?
                               16'(propScaled / {16'h0000, ffDiam}) : propAct[activeSet];

  always_comb begin
    next_state = state;
    unique case (state)
      ST_OFF:   if (enableReq) next_state = ST_CREEP;
      ST_CREEP: if (disableReq) next_state = ST_OFF;
                else if (creepDone) next_state = ST_RAMP;
      ST_RAMP:  if (disableReq) next_state = ST_OFF;
                else next_state = ST_RUN;
      ST_RUN:   if (disableReq) next_state = ST_OFF;
      default:  next_state = ST_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state <= ST_OFF;
      bySerial <= 1'b0;
      activeSet <= 2'h0;
    end else begin
      state <= next_state;
      if (isOff && next_state != ST_OFF) begin
        bySerial <= serEnable && !runSync;
        activeSet <= selSync;
      end
    end
  end

  // Output stage and loop-good.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      driveOut <= ZERO_VOLT;
      loopGood <= 1'b0;
      creepActive <= 1'b0;
      target <= 16'h0000;
    end else begin
      creepActive <= (next_state == ST_CREEP);
      loopGood <= (next_state == ST_RAMP) || (next_state == ST_RUN);
      target <= ffOn ? ffOut : effSetpoint;
      if (next_state == ST_OFF) begin
        driveOut <= zeroLevel;
      end else if (next_state == ST_CREEP) begin
        driveOut <= 16'(zeroLevel + creepRate);
      end else begin
        driveOut <= 16'(zeroLevel + pidOut + (ffOn ? ffOut : 16'h0000));
      end
    end
  end

  // Gain storage: edit copies, and loop copies loaded when editing ends.
  wire editExit = editPrev && !editMode;
  genvar g;
  generate
    for (g = 0; g < NSETS; g++) begin : gSet
      always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
          propSet[g] <= 16'h0000;
          integSet[g] <= 16'h0000;
          derivSet[g] <= 16'h0000;
          propAct[g] <= 16'h0000;
          integAct[g] <= 16'h0000;
          derivAct[g] <= 16'h0000;
        end else begin
          if (editMode && editGainWr && editSet == 2'(g)) begin
            propSet[g] <= editProp;
            integSet[g] <= editInteg;
            derivSet[g] <= editDeriv;
          end
          if (editExit) begin
            propAct[g] <= propSet[g];
            integAct[g] <= integSet[g];
            derivAct[g] <= derivSet[g];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      editPrev <= 1'b0;
      shareEdit <= 16'h0000;
      activeShare <= 16'h0000;
      activeProp <= 16'h0000;
      activeInteg <= 16'h0000;
      activeDeriv <= 16'h0000;
    end else begin
      editPrev <= editMode;
      if (editMode && editGainWr) shareEdit <= editShare;
      if (editExit) activeShare <= shareEdit;
      activeProp <= propAdapt;
      activeInteg <= integAct[activeSet];
      activeDeriv <= derivAct[activeSet];
    end
  end

  // Setpoint editing and storage. Volatile value is lost on any parameter change.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      setpointEdit <= 1'b0;
      setpoint <= 16'h0000;
      nvSetpoint <= 16'h0000;
      nvWrite <= 1'b0;
    end else begin
      nvWrite <= 1'b0;
      if (held) setpointEdit <= 1'b1;
      if (setpointEdit && keyConfirm) begin
        setpointEdit <= 1'b0;
        setpoint <= keyValue;
        nvSetpoint <= keyValue;
        nvWrite <= 1'b1;
      end else if (setpointEdit && keyExit) begin
        setpointEdit <= 1'b0;
        setpoint <= keyValue;
      end else if (serSetpointWr) begin
        setpoint <= serSetpoint;
        if (serSetpointNv) begin
          nvSetpoint <= serSetpoint;
          nvWrite <= 1'b1;
        end
      end else if (paramChange) begin
        setpoint <= nvSetpoint;
      end
    end
  end

  // Calibration storage.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      typePrev <= OUT_VOLT;
      ffValid <= 1'b0;
      ffValue <= 16'h0000;
      ffDiam <= 16'h0000;
      diamS <= 16'h0000;
      voltS <= 16'h0000;
      diamL <= 16'h0000;
      voltL <= 16'h0000;
      diameter <= DIAM_RESET;
    end else begin
      typePrev <= outputType;
      diameter <= diamNow;
      if (calDiamSmall && keyConfirm) begin
        diamS <= keyValue;
        voltS <= diamVolt;
      end
      if (calDiamLarge && keyConfirm) begin
        diamL <= keyValue;
        voltL <= diamVolt;
      end
      if (typePrev != outputType) begin
        ffValid <= 1'b0;
      end else if (calFf && keyConfirm) begin
        ffValue <= ffNew;
        ffDiam <= diamNow;
        ffValid <= 1'b1;
      end
    end
  end
endmodule

// ---- tlseq_pkg.sv ----
/*
  Constants of the tension loop sequencer: widths, output-type codes, gain set
  and calibration layout, and the key hold time.
  Assumes a 25 MHz clock; all data words are unsigned fixed-point values.
*/
package tlseq_pkg;
  localparam int DW = 16;
  localparam int GW = 16;
  localparam int NSETS = 4;
  localparam int SELW = 2;
  localparam int CLK_HZ = 25000000;
  localparam int HOLD_S = 3;
  localparam int HOLD_CYC = HOLD_S * CLK_HZ;
  localparam logic [1:0] OUT_VOLT = 2'h0;
  localparam logic [1:0] OUT_MA0 = 2'h1;
  localparam logic [1:0] OUT_MA4 = 2'h2;
  localparam logic [DW-1:0] ZERO_VOLT = 16'h0000;
  localparam logic [DW-1:0] ZERO_MA0 = 16'h0000;
  localparam logic [DW-1:0] ZERO_MA4 = 16'h3333;
  localparam logic [DW-1:0] PERCENT_FULL = 16'h0064;
  localparam logic [DW-1:0] DIAM_RESET = 16'h0000;
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_CREEP = 4'h2,
    ST_RAMP = 4'h4,
    ST_RUN = 4'h8
  } tlseq_state_t;
endpackage

// ---- tlseq_sync.sv ----
/*
  Two-stage synchroniser for a group of asynchronous digital inputs.
  Assumes a single clock and asynchronous active-low reset.
*/
`timescale 1ns/100ps
module tlseq_sync #(
  parameter int W = 3
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         nrst,
  // Data.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule

// ---- tlseq_hold.sv ----
/*
  Key hold timer: pulses once when a key has been held for HOLD cycles.
  Assumes the key input is synchronous and free of bounce.
*/
`timescale 1ns/100ps
module tlseq_hold #(
  parameter int HOLD = 75000000
) (
  // Clock and reset.
  input  wire logic clock,
  input  wire logic nrst,
  // Key and result.
  input  wire logic key,
  output logic      held
);
  logic [26:0] count;
  wire             atEnd = (count == 27'(HOLD - 1));

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      count <= '0;
      held <= 1'b0;
    end else begin
      held <= key && atEnd;
      if (!key) begin
        count <= '0;
      end else if (count != 27'(HOLD)) begin
        count <= count + 27'h1;
      end
    end
  end
endmodule

// ---- tlseq_checker.sv ----
/*
  Port checker of the tension loop sequencer, bound to tlseq_top.
  Assumes one clock, asynchronous active-low reset and the hand-over timing.
*/
`timescale 1ns/100ps
module tlseq_checker
  import tlseq_pkg::*;
(
  // Clock and reset.
  input wire logic          clock,
  input wire logic          nrst,
  // Inputs of the sequencer.
  input wire logic          runIn,
  input wire logic          serEnable,
  input wire logic          serDisable,
  input wire logic [1:0]    outputType,
  input wire logic [DW-1:0] creepRate,
  input wire logic [DW-1:0] creepThreshold,
  input wire logic          keyConfirm,
  input wire logic [DW-1:0] keyValue,
  input wire logic [DW-1:0] tension,
  // Outputs of the sequencer.
  input wire logic          loopGood,
  input wire logic          creepActive,
  input wire logic [DW-1:0] driveOut,
  input wire logic [1:0]    activeSet,
  input wire logic          setpointEdit,
  input wire logic          nvWrite,
  input wire logic [DW-1:0] nvSetpoint,
  input wire logic          ffValid
);
  wire logic [DW-1:0] zeroLvl = (outputType == OUT_MA4) ? ZERO_MA4 : ZERO_VOLT;
  wire logic          enabled = creepActive | loopGood;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // The type must have stood two edges, because the drive level may follow a registered copy of it.
  a_off_zero: assert property (
    !enabled && $past(nrst) && outputType == $past(outputType) && outputType == $past(outputType, 2)
    |-> driveOut == zeroLvl) else $error("drive not at zero level while off");
  a_ser_start: assert property (
    !enabled && serEnable && !serDisable |=> enabled) else $error("serial enable ignored");
  a_run_start: assert property (
    !enabled && !serEnable && !serDisable && $rose(runIn) ##1 runIn [*2] |=> enabled)
    else $error("run input ignored");
  a_creep_end: assert property (
    creepActive && tension >= creepThreshold |=> !creepActive) else $error("creep past threshold");
  a_good_after: assert property (
    $rose(loopGood) && creepRate != 16'h0000 && creepThreshold != 16'h0000 |-> $past(creepActive))
    else $error("loop good without creep");
  a_ser_stop: assert property (
    enabled && serDisable && !serEnable |=> !enabled) else $error("serial disable ignored");
  a_set_hold: assert property (
    enabled && $past(enabled) |-> $stable(activeSet)) else $error("gain set moved while enabled");
  a_nv_save: assert property (
    setpointEdit && keyConfirm |=> nvWrite && nvSetpoint == $past(keyValue))
    else $error("confirmed setpoint not stored");
  a_type_clear: assert property (
    outputType != $past(outputType) |=> !ffValid) else $error("calibration kept after type change");
endmodule

bind tlseq_top tlseq_checker u_check (.*);

// ---- tlseq_partner.sv ----
/*
  Far side: machine controller run line and line speed, and a web whose
  tension builds while the drive pulls. Assumes the bench gives run requests.
*/
`timescale 1ns/100ps
module tlseq_partner
  import tlseq_pkg::*;
(
  // Clock and reset.
  input wire logic     clock,
  input wire logic     nrst,
  // Run request and drive state.
  input wire logic     runReq,
  input wire logic     creepActive,
  input wire logic     loopGood,
  // Lines towards the sequencer.
  output logic         runIn,
  output logic [DW-1:0] lineSpeed,
  output logic [DW-1:0] tension
);
  wire logic pulling = creepActive | loopGood;
  // Run drops only once the line has stopped, so the run line never makes the drive let go of a moving web.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      runIn <= 1'b0;
      lineSpeed <= 16'h0000;
      tension <= 16'h0000;
    end else begin
      lineSpeed <= runReq ? 16'h0100 : 16'h0000;
      runIn <= runReq | (lineSpeed != 16'h0000);
      tension <= !pulling ? 16'h0000 : (tension < 16'h0400) ? tension + 16'h0010 : tension;
    end
  end
endmodule

// ---- test_tension_loop_sequencer.sv ----
/*
  Self-checking bench of the tension loop sequencer: gain set rows, then
  serial enable, edits, setpoint keys, calibration and reset by hand.
  Assumes the checker is bound to the design; the partner owns run and tension.
*/
`timescale 1ns/100ps
module test_tension_loop_sequencer
  import tlseq_pkg::*;
;
  typedef struct packed {
    logic [1:0]    sel;
    logic [1:0]    ot;
    logic [DW-1:0] zero;
    logic [DW-1:0] rate;
  } tlseq_row_t;
  localparam int HOLD = 10;
  localparam int LIMIT = 5000;
  tlseq_row_t rows [4] = '{'{2'h0, OUT_VOLT, ZERO_VOLT, 16'h0020}, '{2'h1, OUT_MA0, ZERO_MA0, 16'h0040},
                           '{2'h2, OUT_MA4, ZERO_MA4, 16'h0010}, '{2'h3, OUT_VOLT, ZERO_VOLT, 16'h0100}};
  logic          clock, nrst, runReq, runIn, loopGood, creepActive, setpointEdit, nvWrite, ffValid;
  logic          serEnable, serDisable, serSetpointWr, serSetpointNv, setpointExternal, editMode, editGainWr;
  logic          keySetpoint, keyConfirm, keyExit, calDiamSmall, calDiamLarge, calFf, paramChange;
  logic [1:0]    setSelect, outputType, ffMode, editSet, activeSet;
  logic [GW-1:0] editProp, editInteg, editDeriv, activeProp, activeInteg, activeDeriv;
  logic [DW-1:0] serSetpoint, creepRate, creepThreshold, refScale, editShare, keyValue, calTorque;
  logic [DW-1:0] tension, analogRef, diamVolt, lineSpeed, pidOut, driveOut, target, activeShare;
  logic [DW-1:0] nvSetpoint, diameter;
  int            fails = 0, cmpCount = 0, cyc = 0, n;

  tlseq_top #(.HOLD_CYCLES(HOLD)) dut (.*);
  tlseq_partner farSide (.*);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == LIMIT) begin
      fails++;
      wrap_up();
    end
  end

  task automatic step(input int k);
    repeat (k) @(posedge clock);
    #2;
  endtask

  task automatic chk(input string nm, input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmpCount++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmpCount, fails);
    if (fails == 0 && cmpCount > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    {nrst, runReq, serEnable, serDisable, serSetpointWr, serSetpointNv, setpointExternal, editMode} = '0;
    {editGainWr, keySetpoint, keyConfirm, keyExit, calDiamSmall, calDiamLarge, calFf, paramChange} = '0;
    {setSelect, outputType, ffMode, editSet, editProp, editInteg, editDeriv, editShare} = '0;
    {serSetpoint, refScale, keyValue, calTorque, analogRef, diamVolt} = '0;
    creepRate = 16'h0020;
    creepThreshold = 16'h0080;
    pidOut = 16'h0100;
    repeat (2) @(posedge clock);
    #2 nrst = 1'b1;
    step(2);
    chk("driveOut", driveOut, ZERO_VOLT);
    serSetpoint = 16'h0200;
    serSetpointNv = 1'b1;
    pulse(serSetpointWr);
    editMode = 1'b1;
    for (int i = 0; i < NSETS; i++) begin
      editSet = 2'(i);
      editProp = 16'h1000 + 16'(i);
      editInteg = 16'h2000 + 16'(i);
      editDeriv = 16'h3000 + 16'(i);
      editShare = 16'h0010 + 16'(i);
      editGainWr = 1'b1;
      step(1);
    end
    editGainWr = 1'b0;
    editMode = 1'b0;
    step(2);
    foreach (rows[r]) begin
      setSelect = rows[r].sel;
      outputType = rows[r].ot;
      creepRate = rows[r].rate;
      step(3);
      chk("driveOut", driveOut, rows[r].zero);
      runReq = 1'b1;
      for (n = 0; n < 10 && creepActive !== 1'b1; n++) step(1);
      chk("driveOut", driveOut, rows[r].zero + rows[r].rate);
      for (n = 0; n < 40 && loopGood !== 1'b1; n++) step(1);
      step(2);
      chk("loopGood", loopGood, 1'b1);
      chk("target", target, serSetpoint);
      chk("activeSet", activeSet, rows[r].sel);
      chk("activeProp", activeProp, 16'h1000 + rows[r].sel);
      chk("activeDeriv", activeDeriv, 16'h3000 + rows[r].sel);
      chk("activeInteg", activeInteg, 16'h2000 + rows[r].sel);
      chk("activeShare", activeShare, 16'h0013);
      setSelect = ~rows[r].sel;
      step(4);
      chk("activeSet", activeSet, rows[r].sel);
      runReq = 1'b0;
      for (n = 0; n < 10 && loopGood !== 1'b0; n++) step(1);
      chk("driveOut", driveOut, rows[r].zero);
    end
    setpointExternal = 1'b1;
    analogRef = 16'h8000;
    refScale = 16'h8000;
    setSelect = 2'h1;
    step(3);
    pulse(serEnable);
    chk("creepActive", creepActive, 1'b1);
    for (n = 0; n < 40 && loopGood !== 1'b1; n++) step(1);
    step(2);
    chk("target", target, 16'h4000);
    runReq = 1'b1;
    step(4);
    runReq = 1'b0;
    step(6);
    chk("loopGood", loopGood, 1'b1);
    editMode = 1'b1;
    editSet = 2'h1;
    editProp = 16'h5555;
    editShare = 16'h0077;
    pulse(editGainWr);
    step(2);
    chk("activeProp", activeProp, 16'h1001);
    chk("activeShare", activeShare, 16'h0013);
    editMode = 1'b0;
    step(3);
    chk("activeProp", activeProp, 16'h5555);
    chk("activeShare", activeShare, 16'h0077);
    pulse(serDisable);
    chk("loopGood", loopGood, 1'b0);
    chk("driveOut", driveOut, ZERO_VOLT);
    setpointExternal = 1'b0;
    keyValue = 16'h0345;
    keySetpoint = 1'b1;
    step(HOLD + 6);
    keySetpoint = 1'b0;
    chk("setpointEdit", setpointEdit, 1'b1);
    pulse(keyConfirm);
    chk("nvWrite", nvWrite, 1'b1);
    chk("nvSetpoint", nvSetpoint, 16'h0345);
    keyValue = 16'h0123;
    keySetpoint = 1'b1;
    step(HOLD + 6);
    keySetpoint = 1'b0;
    pulse(keyExit);
    step(1);
    chk("nvWrite", nvWrite, 1'b0);
    chk("nvSetpoint", nvSetpoint, 16'h0345);
    chk("target", target, 16'h0123);
    pulse(paramChange);
    step(1);
    chk("target", target, 16'h0345);
    calDiamSmall = 1'b1;
    keyValue = 16'h0100;
    diamVolt = 16'h0200;
    pulse(keyConfirm);
    calDiamSmall = 1'b0;
    step(1);
    calDiamLarge = 1'b1;
    keyValue = 16'h0300;
    diamVolt = 16'h0600;
    pulse(keyConfirm);
    calDiamLarge = 1'b0;
    step(1);
    ffMode = 2'h1;
    calFf = 1'b1;
    calTorque = 16'h0032;
    diamVolt = 16'h0400;
    pulse(keyConfirm);
    calFf = 1'b0;
    step(2);
    chk("ffValid", ffValid, 1'b1);
    chk("diameter", diameter, 16'h0200);
    chk("target", target, 16'h01a2);
    diamVolt = 16'h0600;
    step(2);
    chk("diameter", diameter, 16'h0300);
    chk("ffFollows", target > 16'h01a2, 1'b1);
    chk("gainFollows", activeProp > 16'h5555, 1'b1);
    ffMode = 2'h2;
    runReq = 1'b1;
    step(3);
    chk("diameter", diameter, 16'h0100);
    pidOut = 16'h0200;
    step(2);
    chk("diameter", diameter, 16'h0080);
    runReq = 1'b0;
    pidOut = 16'h0100;
    outputType = OUT_MA4;
    step(3);
    chk("ffValid", ffValid, 1'b0);
    ffMode = 2'h0;
    nrst = 1'b0;
    step(2);
    chk("driveOut", driveOut, 16'h0000);
    nrst = 1'b1;
    step(2);
    chk("driveOut", driveOut, ZERO_MA4);
    chk("loopGood", loopGood, 1'b0);
    wrap_up();
  end
endmodule
